// file: acp_arith.sv
// combinational arithmetic core: divide, multiply, shift, normalize
`timescale 1ns/1ps
module acp_arith (
   acp_calc_if.core c   // operands in, results out
);
   import acp_pkg::*;

   wire [31:0] val    = c.operand[31:0];
   wire [15:0] divsr  = c.operand[47:32];
   wire [31:0] prod   = 32'(c.operand[15:0]) * 32'(c.operand[47:32]);
   wire [4:0]  sc     = c.control[4:0];
   wire        dz     = (divsr == 16'h0000);
   wire [31:0] q32    = dz ? 32'hffffffff : val / 32'(divsr);
   wire [15:0] r32    = dz ? 16'h0000 : 16'(val % 32'(divsr));
   wire [15:0] q16    = dz ? 16'hffff : val[15:0] / divsr;
   wire [15:0] r16    = dz ? 16'h0000 : val[15:0] % divsr;
   logic [4:0] lz;

   // count of leading zeros for normalize
   always_comb begin
      lz = 5'h1f;
      for (int i = 0; i < 32; i++) begin
         if (val[i]) begin
            lz = 5'(31 - i);
         end
      end
   end

   // result selection; unsigned throughout
   always_comb begin
      c.result = c.operand;
      c.count  = sc;
      c.ovf    = 1'b0;
      case (c.op)
         ACP_OP_DIV32: begin
            c.result = {r32, q32};
            c.ovf    = dz;
         end
         ACP_OP_DIV16: begin
            c.result = {r16, 16'h0000, q16};
            c.ovf    = dz;
         end
         ACP_OP_MUL: begin
            c.result = {c.operand[47:32], prod};
            c.ovf    = (prod[31:16] != 16'h0000);
         end
         ACP_OP_SHIFT: begin
            if (sc == 5'h00) begin
               c.result = {c.operand[47:32], val << lz};
               c.count  = lz;
               c.ovf    = val[31];
            end else if (c.control[CTL_DIR_BIT]) begin
               c.result = {c.operand[47:32], val >> sc};
            end else begin
               c.result = {c.operand[47:32], val << sc};
            end
         end
         default: begin
            c.result = c.operand;
         end
      endcase
   end
endmodule : acp_arith

// file: acp_busy_timer.sv
// down counter that marks the execution phase
`timescale 1ns/1ps
module acp_busy_timer (
   input  wire logic       clk_i,    // core clock
   input  wire logic       arst_n_i, // async reset
   input  wire logic       load_i,   // start pulse
   input  wire logic [5:0] cycles_i, // cycles to run
   output logic            busy_o,   // execution in progress
   output logic            done_o    // last cycle pulse
);
   logic [5:0] remain;

   assign busy_o = (remain != 6'h00);
   assign done_o = (remain == 6'h01);

   // count remaining cycles
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         remain <= 6'h00;
      end else if (load_i) begin
         remain <= cycles_i;
      end else if (busy_o) begin
         remain <= remain - 6'h01;
      end
   end
endmodule : acp_busy_timer

// file: acp_calc_if.sv
// operand and result bundle between sequencer and arithmetic core
`timescale 1ns/1ps
interface acp_calc_if;
   import acp_pkg::*;
   logic [47:0] operand;
   logic [5:0]  control;
   acp_op_e     op;
   logic [47:0] result;
   logic [4:0]  count;
   logic        ovf;
   modport seq  (output operand, control, op, input result, count, ovf);
   modport core (input operand, control, op, output result, count, ovf);
endinterface : acp_calc_if

// file: acp_coprocessor.sv
// arithmetic coprocessor: register file, operation select, sequencing
// Operation
// - write to byte 2 or 3 between byte 0 and byte 5 picks 32/16 divide
// - byte 4 then byte 5 gives 16/16 divide; byte 1 gives multiply
// - byte 5 write or control write starts the chosen calculation
// - calculation runs alone without stalling the core
// - latency 17, 9 and 11 cycles for div32, div16, multiply
// - shift takes 3 cycles at count 1 up to 18 at count 31
// - normalize takes 4 up to 19 cycles
// - final read of byte 5 or byte 3 ends the calculation
// - zero shift count selects normalize, else shift by that count
// - normalize shifts left until top bit set, stores shift count
// - control bit 5 picks shift direction, 1 means right
// - zeros enter at the vacated end during a shift
// - control bit 7 is the read-only sequence error flag
// - byte 0 write arms error checking, final read disarms it
// - any write during execution sets error; a byte 5 or control write also restarts
// - armed data read during execution sets error, work continues
// - error clears only on control register read
// - control bit 6 is the overflow flag of the last operation
// - overflow on divide by zero, product over 16 bits, normalize msb
// - other operations clear overflow; core cannot write it
// - results overwrite operand registers
`timescale 1ns/1ps
module acp_coprocessor (
   input  wire logic       CLK_I,     // core clock, 40 MHz
   input  wire logic       ARST_N_I,  // async reset, active low
   input  wire logic [7:0] ADDR_I,    // special register address
   input  wire logic [7:0] WDATA_I,   // write data
   input  wire logic       WR_I,      // write strobe
   input  wire logic       RD_I,      // read strobe
   output logic      [7:0] RDATA_O,   // read data, registered
   output logic            BUSY_O     // calculation executing
);
   import acp_pkg::*;

   logic [7:0]  data_byte [6];
   logic [5:0]  ctl;          // direction and shift count
   logic        err;
   logic        ovf;
   logic        armed;
   logic        seen_hi;      // byte 2 or 3 written
   logic        seen_b1;
   logic        seen_b4;
   acp_op_e     op;
   acp_op_e     final_op;     // op of last calculation, for final read
   logic [5:0]  cycles;
   wire         busy;
   wire         done;

   acp_calc_if calc ();

   // decode of the byte address
   function automatic logic [2:0] byte_idx(input logic [7:0] a);
      return 3'(a - ADDR_BYTE0);
   endfunction : byte_idx

   // leading zeros of the low word; sets the normalize run time
   function automatic logic [4:0] lead_zeros(input logic [31:0] v);
      logic [4:0] n;
      n = 5'h1f;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            n = 5'(31 - i);
         end
      end
      return n;
   endfunction : lead_zeros

   wire        hit_data  = (ADDR_I >= ADDR_BYTE0) && (ADDR_I <= ADDR_BYTE5);
   wire        hit_ctl   = (ADDR_I == ADDR_CONTROL);
   wire [2:0]  idx       = byte_idx(ADDR_I);
   wire        wr_data   = WR_I && hit_data;
   wire        wr_ctl    = WR_I && hit_ctl;
   wire        rd_data   = RD_I && hit_data;
   wire        rd_ctl    = RD_I && hit_ctl;
   wire        wr_b0     = wr_data && (idx == 3'd0);
   wire        wr_b5     = wr_data && (idx == 3'd5);
   // starting writes choose the operation from the order seen so far
   wire        start_md  = wr_b5 && armed;
   wire        start_sh  = wr_ctl && armed;
   wire        start     = start_md || start_sh;
   wire        final_rd  = rd_data && !busy && armed &&
                           (((final_op == ACP_OP_DIV32 ||
                              final_op == ACP_OP_DIV16) && idx == 3'd5) ||
                            ((final_op == ACP_OP_MUL ||
                              final_op == ACP_OP_SHIFT) && idx == 3'd3));
   wire        err_set   = (busy && (WR_I && (hit_data || hit_ctl))) ||
                           (busy && armed && rd_data);
   wire [4:0]  sc_new    = wr_ctl ? WDATA_I[4:0] : ctl[4:0];
   wire [5:0]  shift_cyc = CYC_SHIFT_BASE + 6'(sc_new[4:1]) + 6'h01;
   // normalize time grows with the shifts it will perform
   wire [4:0]  norm_lz   = lead_zeros({data_byte[3], data_byte[2],
                                       data_byte[1], data_byte[0]});
   wire [5:0]  norm_cyc  = CYC_NORM_BASE + 6'(norm_lz[4:1]) + 6'h01;

   // pick operation type at the start write
   always_comb begin
      op = ACP_OP_NONE;
      if (start_sh) begin
         op = ACP_OP_SHIFT;
      end else if (start_md && seen_hi) begin
         op = ACP_OP_DIV32;
      end else if (start_md && seen_b1) begin
         op = ACP_OP_MUL;
      end else if (start_md && seen_b4) begin
         op = ACP_OP_DIV16;
      end
   end

   // cycle counts; shift and normalize grow with the count
   always_comb begin
      case (op)
         ACP_OP_DIV32: cycles = CYC_DIV32;
         ACP_OP_DIV16: cycles = CYC_DIV16;
         ACP_OP_MUL:   cycles = CYC_MUL;
         ACP_OP_SHIFT: cycles = (sc_new == 5'h00) ?
                                norm_cyc : shift_cyc;
         default:      cycles = 6'h00;
      endcase
   end

   acp_busy_timer u_timer (
      .clk_i    (CLK_I),
      .arst_n_i (ARST_N_I),
      .load_i   (start && op != ACP_OP_NONE),
      .cycles_i (cycles),
      .busy_o   (busy),
      .done_o   (done)
   );

   assign calc.operand = {data_byte[5], data_byte[4], data_byte[3],
                          data_byte[2], data_byte[1], data_byte[0]};
   assign calc.control = ctl;
   assign calc.op      = final_op;

   acp_arith u_arith (
      .c (calc)
   );

   assign BUSY_O = busy;

   // data bytes: core writes, results overwrite at completion
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         for (int i = 0; i < 6; i++) data_byte[i] <= 8'h00;
      end else if (wr_data) begin
         data_byte[idx] <= WDATA_I;
      end else if (done) begin
         for (int i = 0; i < 6; i++)
            data_byte[i] <= calc.result[8*i +: 8];
      end
   end

   // control fields; flags belong to hardware only
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctl <= CONTROL_RESET[5:0];
      end else if (wr_ctl) begin
         ctl <= WDATA_I[5:0];
      end else if (done && final_op == ACP_OP_SHIFT && ctl[4:0] == 5'h00) begin
         ctl[4:0] <= calc.count;
      end
   end

   // overflow reflects the last completed calculation
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ovf <= CONTROL_RESET[CTL_OVF_BIT];
      end else if (done) begin
         ovf <= calc.ovf;
      end
   end

   // error flag: set wins over the clearing read
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         err <= CONTROL_RESET[CTL_ERR_BIT];
      end else if (err_set) begin
         err <= 1'b1;
      end else if (rd_ctl) begin
         err <= 1'b0;
      end
   end

   // arming and write-order tracking
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         armed    <= 1'b0;
         seen_hi  <= 1'b0;
         seen_b1  <= 1'b0;
         seen_b4  <= 1'b0;
         final_op <= ACP_OP_NONE;
      end else begin
         if (wr_b0) begin
            armed   <= 1'b1;
            seen_hi <= 1'b0;
            seen_b1 <= 1'b0;
            seen_b4 <= 1'b0;
         end else if (final_rd) begin
            armed   <= 1'b0;
         end else if (wr_data) begin
            if (idx == 3'd2 || idx == 3'd3) seen_hi <= 1'b1;
            // the later of bytes 1 and 4 decides multiply or divide
            if (idx == 3'd1) begin
               seen_b1 <= 1'b1;
               seen_b4 <= 1'b0;
            end
            if (idx == 3'd4) begin
               seen_b4 <= 1'b1;
               seen_b1 <= 1'b0;
            end
         end
         if (start && op != ACP_OP_NONE) begin
            final_op <= op;
         end
      end
   end

   // registered read data
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         RDATA_O <= 8'h00;
      end else if (rd_data) begin
         RDATA_O <= data_byte[idx];
      end else if (rd_ctl) begin
         RDATA_O <= {err, ovf, ctl};
      end
   end

   // checks
   busy_mul_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (start && op == ACP_OP_MUL) |=>
      busy [*8] ##1 busy ##1 busy ##1 busy ##1 !busy)
      else $error("multiply latency wrong");
   busy_div16_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (start && op == ACP_OP_DIV16) |=> busy [*8] ##1 busy ##1 !busy)
      else $error("div16 latency wrong");
   err_wr_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (busy && WR_I && hit_data) |=> err)
      else $error("busy write not flagged");
   err_rd_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (busy && armed && rd_data) |=> err)
      else $error("busy read not flagged");
   err_hold_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      ($fell(err)) |-> $past(rd_ctl))
      else $error("error cleared without read");
   arm_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      wr_b0 |=> armed)
      else $error("byte 0 write did not arm");
   ovf_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      $changed(ovf) |-> $past(done))
      else $error("overflow moved outside done");
   sel32_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (start_md && seen_hi) |-> op == ACP_OP_DIV32)
      else $error("div32 not selected");
   cov_mul_c: cover property (@(posedge CLK_I) start && op == ACP_OP_MUL);
   cov_div_c: cover property (@(posedge CLK_I) start && op == ACP_OP_DIV32);
   cov_sh_c:  cover property (@(posedge CLK_I) start && op == ACP_OP_SHIFT);
   cov_err_c: cover property (@(posedge CLK_I) err_set);
endmodule : acp_coprocessor

// file: acp_core_model.sv
// behavioural core that issues special register accesses to the coprocessor
`timescale 1ns/1ps
module acp_core_model (
   input  wire logic       clk_i,    // core clock
   output logic      [7:0] addr_o,   // register address
   output logic      [7:0] wdata_o,  // write data
   output logic            wr_o,     // write strobe
   output logic            rd_o      // read strobe
);
   // bus parked at time zero with both strobes low
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // one access, driven just after an edge and taken at the next edge
   task automatic acc(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= w;
      rd_o    <= r;
      @(posedge clk_i);
   endtask : acc
   // release: strobes drop, stale address and data are scrambled
   task automatic idle();
      wr_o    <= 1'b0;
      rd_o    <= 1'b0;
      addr_o  <= ~addr_o;
      wdata_o <= ~wdata_o;
   endtask : idle
endmodule : acp_core_model

// file: acp_pkg.sv
// package for the arithmetic coprocessor: map, fields, timing
package acp_pkg;
   localparam logic [7:0] ADDR_BYTE0   = 8'he9;
   localparam logic [7:0] ADDR_BYTE1   = 8'hea;
   localparam logic [7:0] ADDR_BYTE2   = 8'heb;
   localparam logic [7:0] ADDR_BYTE3   = 8'hec;
   localparam logic [7:0] ADDR_BYTE4   = 8'hed;
   localparam logic [7:0] ADDR_BYTE5   = 8'hee;
   localparam logic [7:0] ADDR_CONTROL = 8'hef;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam int CTL_ERR_BIT = 7;
   localparam int CTL_OVF_BIT = 6;
   localparam int CTL_DIR_BIT = 5;
   localparam logic [5:0] CYC_DIV32 = 6'h11;  // 17 cycles
   localparam logic [5:0] CYC_DIV16 = 6'h09;  // 9 cycles
   localparam logic [5:0] CYC_MUL   = 6'h0b;  // 11 cycles
   localparam logic [5:0] CYC_SHIFT_BASE = 6'h02; // shift: count/2 + 3
   localparam logic [5:0] CYC_NORM_BASE  = 6'h03; // normalize: count/2 + 4
   typedef enum logic [4:0] {
      ACP_OP_NONE  = 5'b00001,
      ACP_OP_DIV32 = 5'b00010,
      ACP_OP_DIV16 = 5'b00100,
      ACP_OP_MUL   = 5'b01000,
      ACP_OP_SHIFT = 5'b10000
   } acp_op_e;
endpackage : acp_pkg

// file: test_acp_coprocessor.sv
// self-checking bench for the arithmetic coprocessor
`timescale 1ns/1ps
module test_acp_coprocessor;
   import acp_pkg::*;
   logic       clk;
   logic       arst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       busy;
   logic       rd_q;
   logic [7:0] exp_q[$];
   logic [7:0] last_exp;
   logic [5:0] ctl_lo;
   int         n_errors;
   int         check_count;

   // 40 MHz core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   acp_coprocessor uut (
      .CLK_I    (clk),
      .ARST_N_I (arst_n),
      .ADDR_I   (addr),
      .WDATA_I  (wdata),
      .WR_I     (wr),
      .RD_I     (rd),
      .RDATA_O  (rdata),
      .BUSY_O   (busy)
   );

   acp_core_model core (
      .clk_i   (clk),
      .addr_o  (addr),
      .wdata_o (wdata),
      .wr_o    (wr),
      .rd_o    (rd)
   );

   // compare a seen value with the expected one
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   // watcher: read data lands one cycle after the strobe
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk) begin
      if (rd_q) begin
         check(rdata, exp_q.pop_front());
      end
   end

   // register read with its expected value noted first
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      last_exp = e;
      core.acc(1'b0, 1'b1, a, 8'h00);
   endtask : rdx

   // count busy cycles; a zero latency only waits
   task automatic busy_len(input int lat);
      int n;
      n = 0;
      core.idle();
      @(negedge clk);
      while (busy === 1'b1 && n < 40) begin
         n++;
         @(negedge clk);
      end
      @(posedge clk);
      if (lat > 0) check(8'(n), 8'(lat));
   endtask : busy_len

   // write operand bytes in the order packed low nibble first
   task automatic load(input logic [47:0] v, input logic [23:0] ord,
                       input int n);
      logic [3:0] k;
      for (int i = 0; i < n; i++) begin
         k = ord[4*i+:4];
         core.acc(1'b1, 1'b0, ADDR_BYTE0 + 8'(k), v[8*k+:8]);
      end
   endtask : load

   // full operation: load, start, time it, read results and control
   task automatic do_op(input logic [47:0] v, input logic [23:0] ord,
      input int n, input logic [7:0] ctlw, input int lat,
      input logic [47:0] res, input int nres, input logic [7:0] ctl_exp);
      load(v, ord, n);
      if (ord == 24'h003210) core.acc(1'b1, 1'b0, ADDR_CONTROL, ctlw);
      busy_len(lat);
      for (int i = 0; i < nres; i++) rdx(ADDR_BYTE0 + 8'(i), res[8*i+:8]);
      rdx(ADDR_CONTROL, ctl_exp);
      ctl_lo = ctl_exp[5:0];
   endtask : do_op

   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   // watchdog against a hung handshake
   initial begin
      #(25 * 20000);
      n_errors++;
      close_out();
   end

   // main sequence
   initial begin
      logic [31:0] a, b, p, q;
      logic [4:0]  cnt;
      int          z;
      n_errors = 0;
      check_count = 0;
      rd_q = 1'b0;
      ctl_lo = 6'h00;
      arst_n = 1'b0;
      void'($urandom(32'h399a));
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdx(ADDR_CONTROL, CONTROL_RESET);
      rdx(8'he8, last_exp);
      $display("test reset done");
      for (z = 0; z < 2; z++) begin
         a = $urandom & (z ? 32'hffff : 32'h00ff);
         b = $urandom & (z ? 32'hffff : 32'h00ff);
         p = a * b;
         do_op({b[15:0], 16'h0, a[15:0]}, 24'h005140, 4, 8'h00, 11,
               {16'h0, p}, 4, {1'b0, p > 32'hffff, ctl_lo});
      end
      a = $urandom;
      b = ($urandom & 32'hffff) | 32'h1;
      q = a / b;
      p = a % b;
      do_op({b[15:0], a}, 24'h543210, 6, 8'h00, 17, {p[15:0], q}, 6,
            {2'b00, ctl_lo});
      for (z = 0; z < 2; z++) begin
         a = $urandom & 32'hffff;
         b = z ? 32'h0 : ($urandom & 32'hff) | 32'h1;
         q = z ? 32'hffff : a / b;
         p = z ? 32'h0 : a % b;
         do_op({b[15:0], 16'h0, a[15:0]}, 24'h005410, 4, 8'h00, 9,
               {p[15:0], 16'h0, q[15:0]}, 6, {1'b0, z == 1, ctl_lo});
      end
      $display("test multiply and divide done");
      for (z = 0; z < 4; z++) begin
         a = $urandom;
         cnt = (z == 0) ? 5'h01 : (z == 1) ? 5'h1f : 5'($urandom_range(31, 1));
         p = z[0] ? a >> cnt : a << cnt;
         do_op({16'h0, a}, 24'h003210, 4, {2'b11, z[0], cnt}, cnt / 2 + 3,
               {16'h0, p}, 4, {2'b00, z[0], cnt});
      end
      for (z = 0; z < 2; z++) begin
         cnt = z ? 5'h00 : 5'($urandom_range(31, 1));
         a = ($urandom | 32'h80000000) >> cnt;
         p = a << cnt;
         do_op({16'h0, a}, 24'h003210, 4, 8'h00, cnt / 2 + 4, {16'h0, p}, 4,
               {1'b0, z == 1, 1'b0, cnt});
      end
      $display("test shift and normalize done");
      a = $urandom;
      load({16'h0, a}, 24'h003210, 4);
      core.acc(1'b1, 1'b0, ADDR_CONTROL, 8'h04);
      rdx(ADDR_BYTE0, a[7:0]);
      rdx(ADDR_CONTROL, 8'hc4);
      core.acc(1'b1, 1'b0, ADDR_CONTROL, 8'h04);
      busy_len(0);
      p = a << 4;
      for (z = 0; z < 4; z++) rdx(ADDR_BYTE0 + 8'(z), p[8*z+:8]);
      rdx(ADDR_CONTROL, 8'h84);
      rdx(ADDR_CONTROL, 8'h04);
      $display("test error flag done");
      core.idle();
      repeat (2) @(posedge clk);
      close_out();
   end
endmodule : test_acp_coprocessor
